// *** design/branch_zero_and_call_exec.v ***
// Execution of the branch-on-zero and two-word call instructions
`timescale 1ns/10ps
`include "branch_call_map.vh"
module branch_zero_and_call_exec
(
  input  wire        clock_i,           // Core clock
  input  wire        sys_rst_i,         // Synchronous reset, active high
  input  wire        instr_valid_i,     // Instruction word presented at Q1
  input  wire [15:0] instr_word_i,      // Fetched instruction word
  input  wire [15:0] next_word_i,       // Second program word, valid by Q4
  input  wire [20:0] pc_i,              // Counter, already past the current word
  input  wire [7:0]  accum_i,           // Accumulator
  input  wire [7:0]  status_i,          // Status register
  input  wire [3:0]  bank_select_register_i, // Bank select register
  output reg  [20:0] pc_load_val_o,     // New counter value
  output reg         pc_load_o,         // Counter load strobe, one clock
  output reg  [20:0] stack_top_o,       // Value pushed to return stack
  output reg         stack_push_o,      // Push strobe, one clock
  output reg  [7:0]  accumulator_shadow_o, // Shadow accumulator
  output reg  [7:0]  flags_shadow_o,    // Shadow status
  output reg  [3:0]  bank_select_shadow_o, // Shadow bank select
  output reg         busy_o,            // High during the extra idle cycle
  output reg  [1:0]  phase_o            // Quarter phase in view
);
  localparam ST_IDLE = 2'h0;
  localparam ST_BZ   = 2'h1;
  localparam ST_CALL = 2'h2;
  localparam ST_NOP  = 2'h3;

  wire [1:0] phase;
  wire       cyc_end;
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [15:0] word_r;
  reg         taken_r;
  reg  [20:0] target_r;
  wire        take_slot;
  wire        push_slot;
  wire        word2_ok;
  wire [20:0] offset_x2;
  wire [20:0] ret_addr;

  function is_bz;
    input [15:0] w;
    begin
      is_bz = (w[15:8] == `BZ_OPC_HI);
    end
  endfunction

  function is_call;
    input [15:0] w;
    begin
      is_call = (w[15:9] == `CALL_OPC_HI);
    end
  endfunction

  quarter_phase_gen u_phase
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .phase_o   (phase),
    .cyc_end_o (cyc_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Slots in the quarter-phase sequence
  assign take_slot = (state_r == ST_IDLE) && (phase == `PHASE_Q1) && instr_valid_i;
  assign push_slot = (state_r == ST_CALL) && (phase == `PHASE_Q3);
  assign word2_ok  = (next_word_i[15:12] == `CALL_WORD2_HI);
  // Offset is sign-extended and doubled, so bit zero is always clear
  assign offset_x2 = {{12{word_r[7]}}, word_r[7:0], 1'b0};
  // pc_i already points past word one; two more bytes skip the second call word
  assign ret_addr  = pc_i + `PC_CALL_STEP - 21'h000002;

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take_slot && is_bz(instr_word_i))
          state_nxt = ST_BZ;
        else if (take_slot && is_call(instr_word_i))
          state_nxt = ST_CALL;
      end
      ST_BZ:
      begin
        if (cyc_end)
          state_nxt = taken_r ? ST_NOP : ST_IDLE;
      end
      ST_CALL:
      begin
        if (cyc_end)
          state_nxt = ST_NOP;
      end
      ST_NOP:
      begin
        if (cyc_end)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and the first word latched at decode
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_IDLE;
      word_r  <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (take_slot)
        word_r <= instr_word_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero flag is read once in Q3 and held, so the Q4 write and the idle cycle agree
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
      taken_r <= 1'b0;
    else if (state_r == ST_BZ && phase == `PHASE_Q3)
      taken_r <= status_i[`STATUS_ZERO_BIT];
    else if (state_nxt == ST_IDLE)
      taken_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target built in Q2: relative sum for the branch, low literal for the call
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
      target_r <= `PC_RESET;
    else if (state_r == ST_BZ && phase == `PHASE_Q2)
      target_r <= pc_i + offset_x2;
    else if (state_r == ST_CALL && phase == `PHASE_Q2)
      target_r <= {12'h000, word_r[7:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter load in Q4; a call whose second word lacks its prefix pushes but never jumps
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      pc_load_val_o <= `PC_RESET;
      pc_load_o     <= 1'b0;
    end
    else
    begin
      pc_load_o <= 1'b0;
      if (state_r == ST_BZ && cyc_end && taken_r)
      begin
        pc_load_val_o <= {target_r[20:1], 1'b0};
        pc_load_o     <= 1'b1;
      end
      else if (state_r == ST_CALL && cyc_end && word2_ok)
      begin
        pc_load_val_o <= {next_word_i[11:0], target_r[8:1], 1'b0};
        pc_load_o     <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return address push in Q3, one clock ahead of the counter write
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      stack_top_o  <= `PC_RESET;
      stack_push_o <= 1'b0;
    end
    else
    begin
      stack_push_o <= 1'b0;
      if (push_slot)
      begin
        stack_top_o  <= ret_addr;
        stack_push_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadows move only with a fast-save call; otherwise they keep the last saved set
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      accumulator_shadow_o <= 8'h00;
      flags_shadow_o       <= 8'h00;
      bank_select_shadow_o <= 4'h0;
    end
    else if (push_slot && word_r[8])
    begin
      accumulator_shadow_o <= accum_i;
      flags_shadow_o       <= status_i;
      bank_select_shadow_o <= bank_select_register_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs; phase_o trails the internal phase by one clock
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      busy_o  <= 1'b0;
      phase_o <= `PHASE_Q1;
    end
    else
    begin
      busy_o  <= (state_nxt == ST_NOP);
      phase_o <= phase;
    end
  end
endmodule

// *** design/branch_call_map.vh ***
// Constants for the zero-branch and call execution block
`ifndef BRANCH_CALL_MAP_VH
`define BRANCH_CALL_MAP_VH
`define BZ_OPC_HI        8'hE0
`define CALL_OPC_HI      7'h76
`define CALL_WORD2_HI    4'hF
`define PC_WIDTH         21
`define PC_RESET         21'h000000
`define PC_CALL_STEP     21'h000004
`define STATUS_ZERO_BIT  2
`define PHASE_Q1         2'h0
`define PHASE_Q2         2'h1
`define PHASE_Q3         2'h2
`define PHASE_Q4         2'h3
`endif

// *** design/quarter_phase_gen.v ***
// Quarter phase counter dividing each instruction cycle into four phases
`timescale 1ns/10ps
`include "branch_call_map.vh"
module quarter_phase_gen
(
  input  wire       clock_i,    // Core clock
  input  wire       sys_rst_i,  // Synchronous reset, active high
  output reg  [1:0] phase_o,    // Current quarter phase
  output reg        cyc_end_o   // High during the last phase of a cycle
);
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      phase_o   <= `PHASE_Q1;
      cyc_end_o <= 1'b0;
    end
    else
    begin
      phase_o   <= phase_o + 2'h1;
      cyc_end_o <= (phase_o == `PHASE_Q3);
    end
  end
endmodule

// *** bench/fetch_side_model.sv ***
// Far-side model: fetch counter and second program word
`timescale 1ns/10ps
module fetch_side_model
(
  input  wire [20:0] here_i,  // Address of the current word
  input  wire [11:0] k_hi_i,  // Upper call target bits
  output wire [20:0] pc_o,    // Counter already past the current word
  output wire [15:0] word2_o  // Second call word
);
  assign pc_o = here_i + 21'h000002;
  assign word2_o = {4'hF, k_hi_i};
endmodule

// *** bench/exec_checker.sv ***
// Assertion checker for the zero-branch and call block
`timescale 1ns/10ps
module exec_checker
(
  input logic        clock_i,                // Core clock
  input logic        sys_rst_i,              // Synchronous reset
  input logic        pc_load_o,              // Counter load strobe
  input logic        stack_push_o,           // Push strobe
  input logic        busy_o,                 // Idle-cycle flag
  input logic [15:0] instr_word_i,           // First program word
  input logic [15:0] next_word_i,            // Second program word
  input logic [20:0] pc_i,                   // Incremented counter
  input logic [20:0] pc_load_val_o,          // Loaded counter value
  input logic [20:0] stack_top_o,            // Pushed return address
  input logic [7:0]  accum_i,                // Accumulator
  input logic [7:0]  status_i,               // Status
  input logic [7:0]  accumulator_shadow_o,   // Shadow accumulator
  input logic [7:0]  flags_shadow_o,         // Shadow status
  input logic [3:0]  bank_select_register_i, // Bank select
  input logic [3:0]  bank_select_shadow_o    // Shadow bank select
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_load_lsb_zero: assert property (pc_load_o |-> !pc_load_val_o[0]) else $error("load lsb set");
  a_load_one_clock: assert property (pc_load_o |=> !pc_load_o) else $error("load held");
  a_push_then_load: assert property (stack_push_o |=> pc_load_o) else $error("no load after push");
  a_idle_cycle_busy: assert property (pc_load_o |-> busy_o[*4] ##1 !busy_o) else $error("busy span");
  a_load_needs_zero: assert property (pc_load_o |-> status_i[2] || $past(stack_push_o)) else $error("bad jump");
  a_branch_target: assert property (pc_load_o && !$past(stack_push_o) |->
    pc_load_val_o == pc_i + {{12{instr_word_i[7]}}, instr_word_i[7:0], 1'b0}) else $error("branch target");
  a_call_target: assert property (pc_load_o && $past(stack_push_o) |->
    pc_load_val_o == {next_word_i[11:0], instr_word_i[7:0], 1'b0}) else $error("call target");
  a_return_addr: assert property (stack_push_o |-> stack_top_o == pc_i + 21'h000002) else $error("return");
  a_shadow_copy: assert property (stack_push_o && instr_word_i[8] |-> {accumulator_shadow_o, flags_shadow_o,
    bank_select_shadow_o} == {accum_i, status_i, bank_select_register_i}) else $error("shadow copy");
  a_shadow_keep: assert property (!(stack_push_o && instr_word_i[8]) |-> $stable({accumulator_shadow_o,
    flags_shadow_o, bank_select_shadow_o})) else $error("shadow moved");
endmodule
bind branch_zero_and_call_exec exec_checker i_chk
(
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .pc_load_o(pc_load_o), .stack_push_o(stack_push_o),
  .busy_o(busy_o), .instr_word_i(instr_word_i), .next_word_i(next_word_i), .pc_i(pc_i),
  .pc_load_val_o(pc_load_val_o), .stack_top_o(stack_top_o), .accum_i(accum_i), .status_i(status_i),
  .accumulator_shadow_o(accumulator_shadow_o), .flags_shadow_o(flags_shadow_o),
  .bank_select_register_i(bank_select_register_i), .bank_select_shadow_o(bank_select_shadow_o)
);

// *** bench/test_branch_zero_and_call_exec.sv ***
// Self-checking bench for the zero-branch and call block
`timescale 1ns/10ps
module test_branch_zero_and_call_exec;
  logic clock_i = 0, sys_rst_i = 1, instr_valid_i = 0;
  logic [15:0] instr_word_i = 16'h0000;
  logic [11:0] k_hi = 12'h000;
  logic [20:0] here = 21'h000100;
  logic [7:0]  accum_i = 8'h00, status_i = 8'h00;
  logic [3:0]  bank_select_register_i = 4'h0;
  wire  [15:0] next_word_i;
  wire  [20:0] pc_i, pc_load_val_o, stack_top_o;
  wire         pc_load_o, stack_push_o, busy_o;
  wire  [7:0]  accumulator_shadow_o, flags_shadow_o;
  wire  [3:0]  bank_select_shadow_o;
  wire  [1:0]  phase_o;
  int          n_errors = 0, total_checks = 0, cyc = 0;
  branch_zero_and_call_exec i_dut
  (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
    .next_word_i(next_word_i), .pc_i(pc_i), .accum_i(accum_i), .status_i(status_i),
    .bank_select_register_i(bank_select_register_i), .pc_load_val_o(pc_load_val_o), .pc_load_o(pc_load_o),
    .stack_top_o(stack_top_o), .stack_push_o(stack_push_o), .accumulator_shadow_o(accumulator_shadow_o),
    .flags_shadow_o(flags_shadow_o), .bank_select_shadow_o(bank_select_shadow_o), .busy_o(busy_o),
    .phase_o(phase_o)
  );
  fetch_side_model i_far (.here_i(here), .k_hi_i(k_hi), .pc_o(pc_i), .word2_o(next_word_i));
  initial forever #5 clock_i = ~clock_i;
  task check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Word is offered for one edge only, so a stuck valid cannot retrigger
  task op(input logic [15:0] w, input logic z);
    logic [19:0] sh;
    logic [20:0] exp_pc;
    logic        call, jump;
    int          tl, tp, nb;
    call = w[15:9] == 7'h76;
    jump = call || (w[15:8] == 8'hE0 && z);
    tl = 0;
    tp = 0;
    nb = 0;
    sh = {accumulator_shadow_o, flags_shadow_o, bank_select_shadow_o};
    // Held at 21 bits so a backward branch wraps as the counter does
    exp_pc = call ? {k_hi, w[7:0], 1'b0} : here + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0};
    instr_word_i = w;
    status_i = {5'h00, z, 2'h0};
    accum_i = accum_i + 8'h3B;
    bank_select_register_i = bank_select_register_i + 4'h5;
    while (phase_o !== 2'h3 || busy_o !== 1'b0)
      @(posedge clock_i) #1;
    instr_valid_i = 1;
    @(posedge clock_i) #1;
    instr_valid_i = 0;
    for (int t = 1; t < 10; t++)
    begin
      @(posedge clock_i) #1;
      if (pc_load_o === 1'b1)
        tl = t;
      if (stack_push_o === 1'b1)
        tp = t;
      if (busy_o === 1'b1)
        nb++;
      if (t == 2)
        check(phase_o, 2'h2);
    end
    check(tl, jump ? 3 : 0);
    check(nb, jump ? 4 : 0);
    check(tp, call ? 2 : 0);
    if (jump)
      check(pc_load_val_o, exp_pc);
    if (call)
    begin
      check(stack_top_o, here + 21'h4);
      check({accumulator_shadow_o, flags_shadow_o, bank_select_shadow_o},
            w[8] ? {accum_i, status_i, bank_select_register_i} : sh);
    end
  endtask
  task t_branch;
    op(16'hE07F, 1);
    op(16'hE080, 1);
    op(16'hE055, 0);
    op(16'hE401, 1);
    $display("branch test done");
  endtask
  task t_call;
    here = 21'h0ABCDE;
    k_hi = 12'hABC;
    op(16'hED12, 0);
    k_hi = 12'h5A5;
    op(16'hEC34, 1);
    $display("call test done");
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (8) @(posedge clock_i);
    #1 sys_rst_i = 0;
    t_branch;
    t_call;
    print_verdict;
  end
endmodule
